// ---- src/capcmp_defines.vh ----
// capture/compare/pwm unit: register offsets, field positions, reset values
// assumes inclusion by bare name from design files
`ifndef CAPCMP_DEFINES_VH
`define CAPCMP_DEFINES_VH
// register indices (printed offset style), byte address is four times the index
`define CC_IDX_CONTROL 8'h17
`define CC_IDX_VALUE_LOW 8'h18
`define CC_IDX_VALUE_HIGH 8'h19
`define CC_IDX_STATUS 8'h1A
`define CC_IDX_MASK 8'h1B
`define CC_IDX_TIMER2_PERIOD 8'h1C
// control fields
`define CC_MODE_LSB 0
`define CC_MODE_MSB 3
`define CC_DUTY_LSB_ZERO_BIT 4
`define CC_DUTY_LSB_ONE_BIT 5
`define CC_CONTROL_MASK 8'h3F
`define CC_CONTROL_RESET 8'h00
`define CC_TIMER2_PERIOD_RESET 8'hFF
// mode codes
`define CC_MODE_OFF 4'h0
`define CC_MODE_CAP_FALL 4'h4
`define CC_MODE_CAP_RISE 4'h5
`define CC_MODE_CAP_RISE4 4'h6
`define CC_MODE_CAP_RISE16 4'h7
`define CC_MODE_CMP_SET 4'h8
`define CC_MODE_CMP_CLR 4'h9
`define CC_MODE_CMP_FLAG 4'hA
`define CC_MODE_CMP_SPECIAL 4'hB
// status bits
`define CC_ST_EVENT 0
`define CC_ST_PERIOD 1
`define CC_ST_WIDTH 2
// capture prescale counts
`define CC_PRESCALE_4 4'h3
`define CC_PRESCALE_16 4'hF
`endif

// ---- src/capcmp_edge_prescaler.v ----
// capture edge detector and prescaler for the capture modes
// assumes the pin level is already synchronous to mclk_in
`timescale 1ns/1ps
`include "capcmp_defines.vh"
module capcmp_edge_prescaler
(
    input wire mclk_in,
    input wire reset_n_in,
    input wire enable_in,
    input wire [3:0] mode_in,
    input wire pin_in,
    output wire capture_out
);
    reg pin_last_reg;
    reg [3:0] count_reg;
    reg [3:0] count_next;
    reg fire;
    wire rise;
    wire fall;

    assign rise = pin_in & ~pin_last_reg;
    assign fall = ~pin_in & pin_last_reg;
    assign capture_out = fire;

    always @*
    begin
        fire = 1'b0;
        count_next = count_reg;
        case (mode_in)
            `CC_MODE_CAP_FALL: fire = fall; // RULE6
            `CC_MODE_CAP_RISE: fire = rise; // RULE10
            `CC_MODE_CAP_RISE4:
            begin
                if (rise)
                begin
                    fire = (count_reg >= `CC_PRESCALE_4); // RULE10
                    count_next = fire ? 4'h0 : count_reg + 4'h1;
                end
            end
            `CC_MODE_CAP_RISE16:
            begin
                if (rise)
                begin
                    fire = (count_reg == `CC_PRESCALE_16); // RULE10
                    count_next = count_reg + 4'h1;
                end
            end
            default: count_next = 4'h0;
        endcase
    end

    always @(posedge mclk_in)
    begin
        if (!reset_n_in || !enable_in)
        begin
            pin_last_reg <= 1'b0;
            count_reg <= 4'h0;
        end
        else
        begin
            pin_last_reg <= pin_in;
            count_reg <= count_next;
        end
    end
endmodule

// ---- src/capcmp_pwm_gen.v ----
// pwm waveform generator with 10-bit duty against the timer two time base
// assumes timer two count and prescale phase arrive from the timer block
`timescale 1ns/1ps
`include "capcmp_defines.vh"
module capcmp_pwm_gen
(
    input wire mclk_in,
    input wire reset_n_in,
    input wire enable_in,
    input wire [7:0] timer_two_count_in,
    input wire [1:0] timer_two_phase_in,
    input wire [7:0] period_in,
    input wire [9:0] duty_in,
    output reg pwm_out,
    output reg period_end_out
);
    reg [9:0] duty_latched_reg;
    wire [9:0] fine_count;
    wire at_period;

    assign fine_count = {timer_two_count_in, timer_two_phase_in};
    assign at_period = (timer_two_count_in == period_in) && (timer_two_phase_in == 2'b11);

    // duty is reloaded only at period end so a write never makes a glitch
    always @(posedge mclk_in)
    begin
        if (!reset_n_in || !enable_in)
        begin
            duty_latched_reg <= 10'h000;
            pwm_out <= 1'b0;
            period_end_out <= 1'b0;
        end
        else
        begin
            period_end_out <= at_period;
            if (at_period)
            begin
                duty_latched_reg <= duty_in;
                pwm_out <= (duty_in != 10'h000);
            end
            else if (fine_count + 10'h001 >= duty_latched_reg)
            begin
                pwm_out <= 1'b0;
            end
        end
    end
endmodule

// ---- src/capcmp_unit.v ----
// capture/compare/pwm unit with AHB-Lite register slave and interrupt
// assumes timer one, timer two and the converter are outside, in this clock domain
// Overview of operation
// RULE1: one 16-bit value register serves capture, compare and pwm duty.
// RULE2: the value register is reachable as separate low and high bytes.
// RULE3: capture and compare use timer one; pwm uses timer two.
// RULE4: control at 17h; top two bits read zero; resets to zero.
// RULE5: mode 0000 disables the unit and resets its internal state.
// RULE6: mode 0100 captures timer one on each falling pin edge.
// RULE7: mode 1011 match sets flag, pin unchanged, clears timer, starts conversion if enabled.
// RULE8: modes 11xx are pwm; two control bits give duty low bits.
// RULE9: a configuration routing bit chooses which of two port lines carries the pin.
// RULE10: modes 0101-0111 capture every rise, fourth rise, sixteenth rise; flag set.
// RULE11: modes 1000-1010 match sets flag and drives pin high, low or unchanged.
// RULE12: timer one must run synchronously for special-event clearing to work.
// RULE13: a software timer one write beats a coincident special-event clear.
// RULE14: in special-event mode the value register acts as timer one period.
`timescale 1ns/1ps
`include "capcmp_defines.vh"
module capcmp_unit
(
    input wire mclk_in,
    input wire reset_n_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    input wire [15:0] timer_one_count_in,
    input wire timer_one_write_in,
    input wire [7:0] timer_two_count_in,
    input wire [1:0] timer_two_phase_in,
    input wire converter_enabled_in,
    input wire pin_route_select_in,
    input wire port_b_line_two_in,
    input wire port_b_line_three_in,
    output wire port_b_line_two_out,
    output wire port_b_line_two_oe_out,
    output wire port_b_line_three_out,
    output wire port_b_line_three_oe_out,
    output reg timer_one_clear_out,
    output reg conversion_start_out,
    output wire irq_out
);
    reg [7:0] capcmp_control_reg;
    reg [7:0] capcmp_value_low_reg;
    reg [7:0] capcmp_value_high_reg;
    reg [7:0] timer_two_period_reg;
    reg [2:0] status_reg;
    reg [2:0] mask_reg;
    reg [2:0] status_next;
    reg compare_pin_reg;
    reg match_last_reg;
    reg [31:0] rdata_reg;
    reg wr_pending_reg;
    reg [7:0] wr_index_reg;
    reg [7:0] rd_index;
    reg [31:0] rdata_next;

    wire [3:0] mode;
    wire unit_on;
    wire capture_mode;
    wire compare_mode;
    wire pwm_mode;
    wire [15:0] capcmp_value;
    wire capture_fire;
    wire match;
    wire match_rise;
    wire pin_level;
    wire pin_drive;
    wire pwm_level;
    wire pwm_period_end;
    wire [9:0] duty;
    wire bus_take;
    wire [7:0] take_index;
    wire [2:0] clr_bits;

    assign mode = capcmp_control_reg[`CC_MODE_MSB:`CC_MODE_LSB];
    assign unit_on = (mode != `CC_MODE_OFF); // RULE5
    assign capture_mode = (mode[3:2] == 2'b01);
    assign compare_mode = (mode[3:2] == 2'b10);
    assign pwm_mode = (mode[3:2] == 2'b11); // RULE8
    assign capcmp_value = {capcmp_value_high_reg, capcmp_value_low_reg}; // RULE1
    assign duty = {capcmp_value_low_reg,
                   capcmp_control_reg[`CC_DUTY_LSB_ONE_BIT],
                   capcmp_control_reg[`CC_DUTY_LSB_ZERO_BIT]}; // RULE8

    // selected port line feeds capture input
    assign pin_level = pin_route_select_in ? port_b_line_three_in : port_b_line_two_in; // RULE9

    capcmp_edge_prescaler u_edge
    (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .enable_in(capture_mode),
        .mode_in(mode),
        .pin_in(pin_level),
        .capture_out(capture_fire)
    );

    capcmp_pwm_gen u_pwm
    (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .enable_in(pwm_mode),
        .timer_two_count_in(timer_two_count_in), // RULE3
        .timer_two_phase_in(timer_two_phase_in),
        .period_in(timer_two_period_reg),
        .duty_in(duty),
        .pwm_out(pwm_level),
        .period_end_out(pwm_period_end)
    );

    // compare against timer one; act once on the first cycle of equality
    assign match = compare_mode && (timer_one_count_in == capcmp_value); // RULE3
    assign match_rise = match && !match_last_reg;

    // pin drive and routing to one of the two port lines
    assign pin_drive = pwm_mode ? pwm_level : compare_pin_reg;
    assign port_b_line_two_out = pin_drive;
    assign port_b_line_three_out = pin_drive;
    assign port_b_line_two_oe_out = (pwm_mode | compare_mode) & ~pin_route_select_in; // RULE9
    assign port_b_line_three_oe_out = (pwm_mode | compare_mode) & pin_route_select_in; // RULE9

    always @(posedge mclk_in)
    begin
        if (!reset_n_in || !unit_on)
        begin
            compare_pin_reg <= 1'b0; // RULE5
            match_last_reg <= 1'b0;
            timer_one_clear_out <= 1'b0;
            conversion_start_out <= 1'b0;
        end
        else
        begin
            match_last_reg <= match;
            timer_one_clear_out <= 1'b0;
            conversion_start_out <= 1'b0;
            if (match_rise)
            begin
                case (mode)
                    `CC_MODE_CMP_SET: compare_pin_reg <= 1'b1; // RULE11
                    `CC_MODE_CMP_CLR: compare_pin_reg <= 1'b0; // RULE11
                    `CC_MODE_CMP_FLAG: compare_pin_reg <= compare_pin_reg; // RULE11
                    `CC_MODE_CMP_SPECIAL:
                    begin
                        // a coincident software write to timer one wins over the clear
                        timer_one_clear_out <= ~timer_one_write_in; // RULE7 RULE13 RULE14 RULE12
                        conversion_start_out <= converter_enabled_in; // RULE7
                    end
                    default: compare_pin_reg <= compare_pin_reg;
                endcase
            end
        end
    end

    // AHB-Lite slave: zero wait states, writes land at the data phase edge
    assign bus_take = hsel_in && hready_in && htrans_in[1];
    assign take_index = haddr_in[9:2];
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = rdata_reg;
    assign clr_bits = (wr_pending_reg && wr_index_reg == `CC_IDX_STATUS) ? hwdata_in[2:0] : 3'b000;

    always @*
    begin
        rd_index = take_index;
        case (rd_index)
            `CC_IDX_CONTROL: rdata_next = {24'h000000, capcmp_control_reg & `CC_CONTROL_MASK}; // RULE4
            `CC_IDX_VALUE_LOW: rdata_next = {24'h000000, capcmp_value_low_reg}; // RULE2
            `CC_IDX_VALUE_HIGH: rdata_next = {24'h000000, capcmp_value_high_reg}; // RULE2
            `CC_IDX_STATUS: rdata_next = {29'h0, status_reg};
            `CC_IDX_MASK: rdata_next = {29'h0, mask_reg};
            `CC_IDX_TIMER2_PERIOD: rdata_next = {24'h000000, timer_two_period_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    // events are sticky; a set in the same cycle as a clear wins
    always @*
    begin
        status_next = status_reg & ~clr_bits;
        if (capture_fire || match_rise)
        begin
            status_next[`CC_ST_EVENT] = 1'b1; // RULE7 RULE10 RULE11
        end
        if (pwm_period_end)
        begin
            status_next[`CC_ST_PERIOD] = 1'b1;
        end
        if (pwm_mode && pwm_period_end && duty == 10'h000)
        begin
            status_next[`CC_ST_WIDTH] = 1'b1;
        end
    end

    assign irq_out = |(status_reg & mask_reg);

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            capcmp_control_reg <= `CC_CONTROL_RESET; // RULE4
            capcmp_value_low_reg <= 8'h00;
            capcmp_value_high_reg <= 8'h00;
            timer_two_period_reg <= `CC_TIMER2_PERIOD_RESET;
            status_reg <= 3'b000;
            mask_reg <= 3'b000;
            rdata_reg <= 32'h00000000;
            wr_pending_reg <= 1'b0;
            wr_index_reg <= 8'h00;
        end
        else
        begin
            status_reg <= status_next;
            wr_pending_reg <= bus_take && hwrite_in;
            wr_index_reg <= take_index;
            if (bus_take && !hwrite_in)
            begin
                rdata_reg <= rdata_next;
            end
            if (capture_fire)
            begin
                capcmp_value_low_reg <= timer_one_count_in[7:0]; // RULE6 RULE10
                capcmp_value_high_reg <= timer_one_count_in[15:8];
            end
            if (wr_pending_reg)
            begin
                case (wr_index_reg)
                    `CC_IDX_CONTROL: capcmp_control_reg <= hwdata_in[7:0] & `CC_CONTROL_MASK; // RULE4
                    `CC_IDX_VALUE_LOW: capcmp_value_low_reg <= hwdata_in[7:0]; // RULE2
                    `CC_IDX_VALUE_HIGH: capcmp_value_high_reg <= hwdata_in[7:0]; // RULE2
                    `CC_IDX_MASK: mask_reg <= hwdata_in[2:0];
                    `CC_IDX_TIMER2_PERIOD: timer_two_period_reg <= hwdata_in[7:0];
                    // status is cleared through clr_bits; a pipelined next address must not be lost
                    default: ;
                endcase
            end
        end
    end
endmodule

// ---- test/capcmp_timers_model.sv ----
// timer one and timer two time bases beside the capture/compare/pwm unit
// assumes the unit's clock; the bench loads timer one and may stop it
`timescale 1ns/1ps
module capcmp_timers_model
#(
    parameter PERIOD = 8'h0F
)
(
    input wire mclk_in,
    input wire run_in,
    input wire load_in,
    input wire [15:0] load_value_in,
    input wire clear_in,
    output reg [15:0] count_out = 16'h0000,
    output reg [7:0] t2_count_out = 8'h00,
    output reg [1:0] t2_phase_out = 2'h0
);
    // timer one counts on the unit's clock, so a special-event clear lands unless a load comes in the same cycle
    always @(posedge mclk_in)
    begin
        if (load_in)
            count_out <= load_value_in;
        else if (clear_in)
            count_out <= 16'h0000;
        else if (run_in)
            count_out <= count_out + 16'h0001;
        t2_phase_out <= t2_phase_out + 2'h1;
        if (t2_phase_out == 2'h3)
            t2_count_out <= (t2_count_out == PERIOD) ? 8'h00 : t2_count_out + 8'h01;
    end
endmodule

// ---- test/capcmp_unit_sva.sv ----
// port checker for the capture/compare/pwm unit, bound below
// assumes word-only single bus transfers and one clock domain
`timescale 1ns/1ps
module capcmp_unit_sva
(
    input wire mclk_in,
    input wire reset_n_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    input wire [31:0] hrdata_out,
    input wire [15:0] timer_one_count_in,
    input wire timer_one_write_in,
    input wire converter_enabled_in,
    input wire pin_route_select_in,
    input wire port_b_line_two_out,
    input wire port_b_line_two_oe_out,
    input wire port_b_line_three_oe_out,
    input wire timer_one_clear_out,
    input wire conversion_start_out
);
    reg wr_reg, rd_reg, eq_reg, special_reg;
    reg [7:0] adr_reg, ctl_reg;
    reg [15:0] val_reg;
    wire [3:0] mode = ctl_reg[3:0];
    wire hit = (timer_one_count_in == val_reg) && !eq_reg;
    // shadow of control and value, taken from bus writes
    always @(posedge mclk_in)
    begin
        wr_reg <= reset_n_in && hsel_in && hready_in && htrans_in[1] && hwrite_in;
        rd_reg <= reset_n_in && hsel_in && hready_in && htrans_in[1] && !hwrite_in;
        adr_reg <= haddr_in[9:2];
        eq_reg <= timer_one_count_in == val_reg;
        special_reg <= mode == 4'hB && hit;
        if (!reset_n_in)
            ctl_reg <= 8'h00;
        else if (wr_reg && adr_reg == 8'h17)
            ctl_reg <= hwdata_in[7:0];
        if (!reset_n_in)
            val_reg <= 16'h0000;
        else if (wr_reg && adr_reg[7:1] == 7'h0C)
            val_reg <= adr_reg[0] ? {hwdata_in[7:0], val_reg[7:0]} : {val_reg[15:8], hwdata_in[7:0]};
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_special;
        (mode == 4'hB && hit && !timer_one_write_in) ##1 !timer_one_write_in;
    endsequence
    sequence s_idle;
        (mode == 4'h0) [*2];
    endsequence
    a_special_clear: assert property (s_special |-> timer_one_clear_out)
        else $error("special match gave no timer clear");
    a_clear_cause: assert property (timer_one_clear_out |-> special_reg ##1 !timer_one_clear_out)
        else $error("timer clear without special match");
    a_conv_start: assert property (mode == 4'hB && hit && converter_enabled_in |=> conversion_start_out)
        else $error("special match gave no conversion start");
    a_conv_gate: assert property (conversion_start_out |-> special_reg && $past(converter_enabled_in))
        else $error("conversion start while converter off");
    a_route_two: assert property (port_b_line_two_oe_out |-> !pin_route_select_in && !port_b_line_three_oe_out)
        else $error("line two driven while not routed");
    a_route_three: assert property (port_b_line_three_oe_out |-> pin_route_select_in)
        else $error("line three driven while not routed");
    a_off_idle: assert property (s_idle |-> !port_b_line_two_oe_out && !port_b_line_three_oe_out)
        else $error("disabled unit still drives a pin");
    a_cmp_high: assert property (mode == 4'h8 && hit |=> port_b_line_two_out)
        else $error("set-on-match left pin low");
    a_cmp_low: assert property (mode == 4'h9 && hit |=> !port_b_line_two_out)
        else $error("clear-on-match left pin high");
    a_cmp_keep: assert property ((mode == 4'hA || mode == 4'hB) && hit |=> $stable(port_b_line_two_out))
        else $error("flag-only match moved the pin");
    a_capture_quiet: assert property ((mode[3:2] == 2'b01) [*2] |-> !port_b_line_two_oe_out && !port_b_line_three_oe_out)
        else $error("capture mode drives a pin");
    a_pwm_drive: assert property ((mode[3:2] == 2'b11) [*2] |-> port_b_line_two_oe_out || port_b_line_three_oe_out)
        else $error("pwm mode drives no pin");
    a_ctl_read: assert property (rd_reg && adr_reg == 8'h17 |-> hrdata_out[7:0] == {2'b00, ctl_reg[5:0]})
        else $error("control read back wrong");
endmodule

bind capcmp_unit capcmp_unit_sva u_capcmp_unit_sva (.*);

// ---- test/test_capcmp_unit.sv ----
// self-checking bench for the capture/compare/pwm unit
// assumes the timers model on the far side and the checker bound in its own file
`timescale 1ns/1ps
module test_capcmp_unit;
    reg clk = 0, rst_n = 0, hwrite = 0, t1_wr = 0, run = 1, conv_en = 1, route = 0;
    reg [31:0] haddr = 0, hwdata = 0, rd;
    reg [1:0] htrans = 0, drv = 0;
    reg [15:0] t1_val = 0;
    reg [11:0] rows [0:7];
    wire [31:0] hrdata;
    wire [15:0] t1;
    wire [7:0] t2;
    wire [1:0] t2_ph;
    wire hready, hresp, o2, e2, o3, e3, clr, conv, irq;
    wire [1:0] pin = {e3 ? o3 : drv[1], e2 ? o2 : drv[0]};
    integer n_errors = 0, comparisons = 0, n_clr = 0, n_conv = 0, cyc = 0, last = 0, gap = 0;
    integer i, k, w, h0, h1;
    capcmp_unit DUT (.mclk_in(clk), .reset_n_in(rst_n), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .timer_one_count_in(t1), .timer_one_write_in(t1_wr),
        .timer_two_count_in(t2), .timer_two_phase_in(t2_ph), .converter_enabled_in(conv_en),
        .pin_route_select_in(route), .port_b_line_two_in(pin[0]), .port_b_line_three_in(pin[1]),
        .port_b_line_two_out(o2), .port_b_line_two_oe_out(e2), .port_b_line_three_out(o3),
        .port_b_line_three_oe_out(e3), .timer_one_clear_out(clr), .conversion_start_out(conv), .irq_out(irq));
    capcmp_timers_model #(.PERIOD(8'h0F)) timers (.mclk_in(clk), .run_in(run), .load_in(t1_wr),
        .load_value_in(t1_val), .clear_in(clr), .count_out(t1), .t2_count_out(t2), .t2_phase_out(t2_ph));
    initial forever #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        n_conv <= n_conv + conv;
        if (clr)
        begin
            n_clr <= n_clr + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end
    task complete_run;
    begin
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input [95:0] what, input [15:0] exp, input [15:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("BAD %0s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task bus(input w_in, input [7:0] idx, input [7:0] d);
    begin
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w_in;
        htrans <= 2'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    end
    endtask
    task rdc(input [95:0] what, input [7:0] idx, input [15:0] exp);
    begin
        bus(1'b0, idx, 8'h00);
        chk(what, exp, rd[15:0]);
        chk("hresp", 16'h0000, {15'h0, hresp});
    end
    endtask
    task cycles(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task pulse(input r);
    begin
        drv[r] <= 1'b1;
        cycles(2);
        drv[r] <= 1'b0;
        cycles(2);
    end
    endtask
    task measure(output integer h);
    begin
        cycles(150);
        h = 0;
        repeat (64) @(posedge clk) h = h + pin[0];
    end
    endtask
    // load timer one for one cycle, as a software write would
    task load(input [15:0] v);
    begin
        t1_wr <= 1'b1;
        t1_val <= v;
        cycles(1);
        t1_wr <= 1'b0;
    end
    endtask
    initial
    begin
        #1000000;
        n_errors = n_errors + 1;
        complete_run;
    end
    initial
    begin
        // mode, route, edge count, pin after match, conversion expected
        rows[0] = {4'h4, 1'b0, 5'h01, 2'h0};
        rows[1] = {4'h5, 1'b1, 5'h01, 2'h0};
        rows[2] = {4'h6, 1'b0, 5'h04, 2'h0};
        rows[3] = {4'h7, 1'b1, 5'h10, 2'h0};
        rows[4] = {4'h8, 1'b0, 5'h00, 2'h2};
        rows[5] = {4'hA, 1'b0, 5'h00, 2'h2};
        rows[6] = {4'h9, 1'b1, 5'h00, 2'h0};
        rows[7] = {4'hB, 1'b1, 5'h00, 2'h1};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b1, 8'h1B, 8'h01);
        for (i = 0; i < 8; i = i + 1)
        begin
            route <= rows[i][7];
            if (!rows[i][11])
            begin
                bus(1'b1, 8'h17, 8'h00);
                bus(1'b1, 8'h17, {4'h0, rows[i][11:8]});
                run <= 1'b0;
                load({12'hA5C, rows[i][11:8]});
                for (k = 1; k < rows[i][6:2]; k = k + 1)
                    pulse(rows[i][7]);
                rdc("early", 8'h1A, 16'h0000);
                pulse(rows[i][7]);
                rdc("flag", 8'h1A, 16'h0001);
                bus(1'b0, 8'h18, 8'h00);
                k = rd[7:0];
                rdc("value", 8'h19, t1_val >> 8);
                chk("val_low", t1_val & 16'h00FF, k[15:0]);
            end
            else
            begin
                bus(1'b1, 8'h18, 8'h30);
                bus(1'b1, 8'h19, 8'h00);
                bus(1'b1, 8'h17, {4'h0, rows[i][11:8]});
                run <= 1'b1;
                k = n_conv;
                load(16'h0000);
                for (w = 0; w < 100 && irq !== 1'b1; w = w + 1) @(posedge clk);
                cycles(1);
                chk("pin", {15'h0, rows[i][1]}, {15'h0, pin[rows[i][7]]});
                chk("drive", 16'h0001, {15'h0, rows[i][7] ? e3 : e2});
                chk("convert", {15'h0, rows[i][0]}, n_conv - k);
            end
            bus(1'b1, 8'h1A, 8'h01);
            rdc("cleared", 8'h1A, 16'h0000);
            chk("irq", 16'h0000, {15'h0, irq});
        end
        cycles(120);
        chk("period", 16'h0032, gap);
        conv_en <= 1'b0;
        k = n_conv;
        h0 = n_clr;
        cycles(120);
        chk("no_conv", 16'h0000, n_conv - k);
        chk("clears", 16'h0001, {15'h0, n_clr > h0});
        bus(1'b1, 8'h1B, 8'h00);
        while (clr !== 1'b1) @(posedge clk);
        // let the standing clear pulse be counted before taking the baseline
        cycles(1);
        h0 = n_clr;
        t1_wr <= 1'b1;
        t1_val <= 16'h0030;
        cycles(10);
        t1_wr <= 1'b0;
        chk("write_wins", 16'h0000, n_clr - h0);
        chk("masked", 16'h0000, {15'h0, irq});
        bus(1'b1, 8'h1B, 8'h01);
        cycles(1);
        chk("unmasked", 16'h0001, {15'h0, irq});
        bus(1'b1, 8'h1A, 8'h01);
        route <= 1'b0;
        bus(1'b1, 8'h1C, 8'h0F);
        bus(1'b1, 8'h18, 8'h08);
        bus(1'b1, 8'h17, 8'h0C);
        measure(h0);
        bus(1'b1, 8'h17, 8'h3C);
        measure(h1);
        chk("duty_lsb", 16'h0003, h1 - h0);
        rst_n <= 1'b0;
        cycles(3);
        rst_n <= 1'b1;
        rdc("ctl_rst", 8'h17, 16'h0000);
        rdc("t2_rst", 8'h1C, 16'h00FF);
        rdc("low_rst", 8'h18, 16'h0000);
        rdc("st_rst", 8'h1A, 16'h0000);
        bus(1'b1, 8'h17, 8'hFF);
        rdc("ctl_top", 8'h17, 16'h003F);
        rdc("unmapped", 8'h20, 16'h0000);
        complete_run;
    end
endmodule
